// file: ifd_pkg.sv
// Constants and types for the instruction field decoder
package ifd_pkg;
	localparam int unsigned AW = 8;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_FLD  = 8'h08;
	localparam logic [7:0] OFS_DISP = 8'h0c;
	localparam logic [7:0] OFS_IMM  = 8'h10;
	localparam int unsigned CTRL_D    = 0;
	localparam int unsigned CTRL_PROT = 1;
	localparam logic [1:0] CTRL_RST   = 2'h0;

	// ----------------------------------------
	// Byte codes and field encodings
	// ----------------------------------------
	localparam logic [7:0] PFX_OPSZ = 8'h66;
	localparam logic [7:0] PFX_ADSZ = 8'h67;
	localparam logic [7:0] OPC_ESC  = 8'h0f;
	localparam int unsigned PFX_N = 11;
	localparam logic [7:0] PFX_LIST [PFX_N] = '{8'h66, 8'h67, 8'h26, 8'h2e, 8'h36, 8'h3e,
		8'h64, 8'h65, 8'hf0, 8'hf2, 8'hf3};
	localparam logic [1:0] MOD_MEM = 2'h0;
	localparam logic [1:0] MOD_D8  = 2'h1;
	localparam logic [1:0] MOD_DW  = 2'h2;
	localparam logic [1:0] MOD_REG = 2'h3;
	localparam logic [2:0] RM_SIB    = 3'h4;
	localparam logic [2:0] RM_D16    = 3'h6;
	localparam logic [2:0] RM_D32    = 3'h5;
	localparam logic [2:0] BASE_NONE = 3'h5;
	localparam logic [1:0] IMM_NONE = 2'h0;
	localparam logic [1:0] IMM_B    = 2'h1;
	localparam logic [1:0] IMM_W    = 2'h2;
	localparam logic [1:0] IMM_FULL = 2'h3;
	localparam logic [1:0] SEG_BAD_HI = 2'h3;
	localparam logic [2:0] LEN_0 = 3'h0;
	localparam logic [2:0] LEN_1 = 3'h1;
	localparam logic [2:0] LEN_2 = 3'h2;
	localparam logic [2:0] LEN_4 = 3'h4;
	localparam logic [3:0] BE_LO = 4'h1;
	localparam logic [3:0] BE_HI = 4'h2;
	localparam logic [3:0] BE_W  = 4'h3;
	localparam logic [3:0] BE_D  = 4'hf;

	typedef enum logic [2:0] {st_op, st_op2, st_modrm, st_sib, st_disp, st_imm} ifd_state_t;

	function automatic logic ifd_is_pfx(input logic [7:0] b);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < PFX_N; i++)
			hit = hit | (b == PFX_LIST[i]);
		return hit;
	endfunction
endpackage

// file: ifd_decoder.sv
// Instruction field decoder with APB control and status
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// RL1 - Opcode bytes, then optional addressing, index, displacement, immediate in order
// RL2 - Displacement follows addressing or index byte; 8, 16 or 32 bits
// RL3 - Immediate follows all displacement bytes and ends the instruction
// RL4 - Memory forms read an addressing byte; some codes add an index byte
// RL5 - Addressing byte splits into 2-bit mode, 3-bit middle, 3-bit reg/mem
// RL6 - Index byte splits into 2-bit scale, 3-bit index, 3-bit base
// RL7 - Width 0 means byte, 1 means full 16 or 32 bits
// RL8 - Direction bit from the opcode picks data flow way
// RL9 - Sign-extend bit widens byte immediate to operation size
// RL10 - Register selector from opcode or addressing byte fields
// RL11 - Narrow 2-bit and wide 3-bit segment selectors
// RL12 - 4-bit condition field with asserted or negated sense
// RL13 - Default sizes come from the code segment default bit
// RL14 - Real and virtual modes use default bit 0
// RL15 - Size prefixes flip operand and address size independently
// RL16 - Prefixes affect only next instruction, order does not matter
// RL17 - 32-bit forms reachable in every mode through prefixes
// RL18 - Narrow writes leave upper destination bits unchanged
// RL19 - Index byte expected for 32-bit addressing, rm 100, mode not 11
// RL20 - Register codes in order; width 0 codes 100-111 pick high bytes
// RL21 - Segment code map; wide codes 110 and 111 are flagged
// RL22 - Total length is the sum of all field byte counts
module ifd_decoder (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        byte_valid,
	input  wire logic [7:0]  byte_data,
	output logic             byte_ready,
	input  wire logic        attr_modrm,
	input  wire logic [1:0]  attr_imm,
	output logic             dec_valid,
	output logic      [3:0]  dec_len,
	output logic      [3:0]  dec_pfx_cnt,
	output logic             dec_two_byte,
	output logic             dec_has_modrm,
	output logic             dec_has_sib,
	output logic      [7:0]  dec_opcode,
	output logic             dec_w,
	output logic             dec_d,
	output logic             dec_s,
	output logic      [1:0]  dec_mod,
	output logic      [2:0]  dec_mid,
	output logic      [2:0]  dec_rm,
	output logic      [1:0]  dec_ss,
	output logic      [2:0]  dec_index,
	output logic      [2:0]  dec_base,
	output logic      [2:0]  dec_reg_num,
	output logic             dec_reg_hi,
	output logic      [3:0]  dest_be,
	output logic      [1:0]  seg_sel_narrow,
	output logic      [2:0]  seg_sel_wide,
	output logic             dec_seg_bad,
	output logic      [3:0]  dec_cond,
	output logic             dec_cond_neg,
	output logic             dec_op32,
	output logic             dec_adr32,
	output logic      [2:0]  dec_disp_len,
	output logic      [2:0]  dec_imm_len,
	output logic      [31:0] dec_disp,
	output logic      [31:0] dec_imm
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	ifd_pkg::ifd_state_t state;
	ifd_pkg::ifd_state_t next_state;
	logic [1:0]  ctrl;
	logic        op_ovr;
	logic        adr_ovr;
	logic        two_byte;
	logic        has_modrm;
	logic        has_sib;
	logic        fin;
	logic        fin_now;
	logic        go_opc;
	logic        go_imm;
	logic [3:0]  pfx_cnt;
	logic [3:0]  len;
	logic [7:0]  opc;
	logic [7:0]  modrm;
	logic [7:0]  sib;
	logic [2:0]  disp_len;
	logic [2:0]  imm_len;
	logic [2:0]  cnt;
	logic [1:0]  pos;
	logic [31:0] disp_q;
	logic [31:0] imm_q;

	// ----------------------------------------
	// Size resolution and byte classification
	// ----------------------------------------
	wire logic prot_mode = ctrl[ifd_pkg::CTRL_PROT];
	// RL13 RL14 default size bit
	wire logic eff_d = prot_mode & ctrl[ifd_pkg::CTRL_D];
	// RL15 RL17 prefix flips size
	wire logic op32 = eff_d ^ op_ovr;
	wire logic adr32 = eff_d ^ adr_ovr;
	wire logic take = byte_valid & byte_ready;
	wire logic is_pfx = ifd_pkg::ifd_is_pfx(byte_data);
	wire logic is_esc = byte_data == ifd_pkg::OPC_ESC;
	wire logic in_opc = (state == ifd_pkg::st_op) || (state == ifd_pkg::st_op2);
	wire logic [1:0] m_mod = byte_data[7:6];
	wire logic [2:0] m_rm = byte_data[2:0];
	// RL19 index byte needed
	wire logic m_sib = adr32 && m_rm == ifd_pkg::RM_SIB && m_mod != ifd_pkg::MOD_REG;
	// RL2 displacement size from mode
	wire logic [2:0] m_disp = (m_mod == ifd_pkg::MOD_D8) ? ifd_pkg::LEN_1 :
		(m_mod == ifd_pkg::MOD_DW) ? (adr32 ? ifd_pkg::LEN_4 : ifd_pkg::LEN_2) :
		(m_mod == ifd_pkg::MOD_MEM && adr32 && m_rm == ifd_pkg::RM_D32) ? ifd_pkg::LEN_4 :
		(m_mod == ifd_pkg::MOD_MEM && !adr32 && m_rm == ifd_pkg::RM_D16) ? ifd_pkg::LEN_2 :
		ifd_pkg::LEN_0;
	wire logic [2:0] s_disp = (modrm[7:6] == ifd_pkg::MOD_MEM && m_rm == ifd_pkg::BASE_NONE) ?
		ifd_pkg::LEN_4 : disp_len;
	wire logic [2:0] a_imm_len = (attr_imm == ifd_pkg::IMM_B) ? ifd_pkg::LEN_1 :
		(attr_imm == ifd_pkg::IMM_W) ? ifd_pkg::LEN_2 :
		(attr_imm == ifd_pkg::IMM_FULL) ? (op32 ? ifd_pkg::LEN_4 : ifd_pkg::LEN_2) :
		ifd_pkg::LEN_0;
	wire logic [2:0] imm_eff = in_opc ? a_imm_len : imm_len;
	wire logic [2:0] ent_len = (next_state == ifd_pkg::st_disp) ?
		((state == ifd_pkg::st_sib) ? s_disp : m_disp) : imm_eff;

	// ----------------------------------------
	// Published field decode
	// ----------------------------------------
	// RL10 register selector source
	wire logic [2:0] reg_sel = has_modrm ? modrm[5:3] : opc[2:0];
	// RL20 high byte registers
	wire logic reg_hi = !opc[0] && reg_sel[2];
	wire logic [2:0] reg_num = reg_hi ? {1'b0, reg_sel[1:0]} : reg_sel;
	// RL18 RL7 destination lanes
	wire logic [3:0] be = opc[0] ? (op32 ? ifd_pkg::BE_D : ifd_pkg::BE_W) :
		(reg_hi ? ifd_pkg::BE_HI : ifd_pkg::BE_LO);
	// RL9 sign extension of byte immediate
	wire logic imm_sx = opc[1] && imm_len == ifd_pkg::LEN_1;
	wire logic [31:0] imm_x = !imm_sx ? imm_q :
		op32 ? {{24{imm_q[7]}}, imm_q[7:0]} : {16'h0000, {8{imm_q[7]}}, imm_q[7:0]};

	// ----------------------------------------
	// Field sequencer
	// ----------------------------------------
	// RL1 RL4 field order
	always_comb begin
		next_state = state;
		fin_now = 1'b0;
		go_opc = 1'b0;
		go_imm = 1'b0;
		if (take) begin
			unique case (state)
				ifd_pkg::st_op: begin
					if (is_esc)
						next_state = ifd_pkg::st_op2;
					else if (!is_pfx)
						go_opc = 1'b1;
				end
				ifd_pkg::st_op2: go_opc = 1'b1;
				ifd_pkg::st_modrm: begin
					if (m_sib)
						next_state = ifd_pkg::st_sib;
					else if (m_disp != ifd_pkg::LEN_0)
						next_state = ifd_pkg::st_disp;
					else
						go_imm = 1'b1;
				end
				ifd_pkg::st_sib: begin
					if (s_disp != ifd_pkg::LEN_0)
						next_state = ifd_pkg::st_disp;
					else
						go_imm = 1'b1;
				end
				ifd_pkg::st_disp: go_imm = cnt == ifd_pkg::LEN_1;
				ifd_pkg::st_imm: fin_now = cnt == ifd_pkg::LEN_1;
			endcase
		end
		// RL3 immediate last
		if (go_opc && attr_modrm)
			next_state = ifd_pkg::st_modrm;
		else if (go_opc || go_imm) begin
			if (imm_eff != ifd_pkg::LEN_0)
				next_state = ifd_pkg::st_imm;
			else
				fin_now = 1'b1;
		end
	end

	// RL16 prefixes cleared per instruction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ifd_pkg::st_op;
			op_ovr <= 1'b0;
			adr_ovr <= 1'b0;
			pfx_cnt <= 4'h0;
			two_byte <= 1'b0;
			len <= 4'h0;
		end else if (fin) begin
			state <= ifd_pkg::st_op;
			op_ovr <= 1'b0;
			adr_ovr <= 1'b0;
			pfx_cnt <= 4'h0;
			two_byte <= 1'b0;
			len <= 4'h0;
		end else if (take) begin
			state <= next_state;
			len <= len + 4'h1;
			if (state == ifd_pkg::st_op && is_pfx) begin
				op_ovr <= op_ovr | (byte_data == ifd_pkg::PFX_OPSZ);
				adr_ovr <= adr_ovr | (byte_data == ifd_pkg::PFX_ADSZ);
				pfx_cnt <= pfx_cnt + 4'h1;
			end
			if (state == ifd_pkg::st_op && is_esc)
				two_byte <= 1'b1;
		end
	end

	// Field capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opc <= 8'h00;
			has_modrm <= 1'b0;
			imm_len <= 3'h0;
			modrm <= 8'h00;
			sib <= 8'h00;
			has_sib <= 1'b0;
			disp_len <= 3'h0;
		end else if (fin) begin
			has_modrm <= 1'b0;
			has_sib <= 1'b0;
			disp_len <= 3'h0;
			imm_len <= 3'h0;
		end else if (go_opc) begin
			opc <= byte_data;
			has_modrm <= attr_modrm;
			imm_len <= a_imm_len;
		end else if (take && state == ifd_pkg::st_modrm) begin
			modrm <= byte_data;
			disp_len <= m_disp;
			has_sib <= m_sib;
		end else if (take && state == ifd_pkg::st_sib) begin
			sib <= byte_data;
			disp_len <= s_disp;
		end
	end

	// RL2 RL3 little-endian multi-byte fields
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 3'h0;
			pos <= 2'h0;
			disp_q <= 32'h0;
			imm_q <= 32'h0;
		end else if (fin) begin
			disp_q <= 32'h0;
			imm_q <= 32'h0;
		end else if (take) begin
			if (state == ifd_pkg::st_disp)
				disp_q[{pos, 3'h0} +: 8] <= byte_data;
			if (state == ifd_pkg::st_imm)
				imm_q[{pos, 3'h0} +: 8] <= byte_data;
			if (next_state != state) begin
				cnt <= ent_len;
				pos <= 2'h0;
			end else begin
				cnt <= cnt - 3'h1;
				pos <= pos + 2'h1;
			end
		end
	end

	// RL22 fetch held while publishing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fin <= 1'b0;
			byte_ready <= 1'b0;
		end else begin
			fin <= fin_now;
			byte_ready <= !fin_now;
		end
	end

	// ----------------------------------------
	// Result publication
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec_valid <= 1'b0;
			{dec_len, dec_pfx_cnt, dec_two_byte, dec_has_modrm, dec_has_sib} <= 11'h0;
			{dec_opcode, dec_w, dec_d, dec_s} <= 11'h0;
			{dec_mod, dec_mid, dec_rm, dec_ss, dec_index, dec_base} <= 16'h0;
			{dec_reg_num, dec_reg_hi, dest_be} <= 8'h0;
			{seg_sel_narrow, seg_sel_wide, dec_seg_bad} <= 6'h0;
			{dec_cond, dec_cond_neg, dec_op32, dec_adr32} <= 7'h0;
			{dec_disp_len, dec_imm_len} <= 6'h0;
			dec_disp <= 32'h0;
			dec_imm <= 32'h0;
		end else begin
			dec_valid <= fin;
			if (fin) begin
				// RL22 length and field counts
				dec_len <= len;
				dec_pfx_cnt <= pfx_cnt;
				dec_two_byte <= two_byte;
				dec_has_modrm <= has_modrm;
				dec_has_sib <= has_sib;
				dec_opcode <= opc;
				// RL7 RL8 RL9 opcode bits
				dec_w <= opc[0];
				dec_d <= opc[1];
				dec_s <= opc[1];
				// RL5 RL6 addressing splits
				{dec_mod, dec_mid, dec_rm} <= modrm;
				{dec_ss, dec_index, dec_base} <= sib;
				dec_reg_num <= reg_num;
				dec_reg_hi <= reg_hi;
				dest_be <= be;
				// RL11 RL21 segment selectors
				seg_sel_narrow <= opc[4:3];
				seg_sel_wide <= modrm[5:3];
				dec_seg_bad <= modrm[5:4] == ifd_pkg::SEG_BAD_HI;
				// RL12 condition field
				dec_cond <= opc[3:0];
				dec_cond_neg <= opc[0];
				dec_op32 <= op32;
				dec_adr32 <= adr32;
				dec_disp_len <= disp_len;
				dec_imm_len <= imm_len;
				dec_disp <= disp_q;
				dec_imm <= imm_x;
			end
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	wire logic hit_ctrl = paddr == ifd_pkg::OFS_CTRL;
	wire logic hit_stat = paddr == ifd_pkg::OFS_STAT;
	wire logic hit_fld = paddr == ifd_pkg::OFS_FLD;
	wire logic hit_disp = paddr == ifd_pkg::OFS_DISP;
	wire logic hit_imm = paddr == ifd_pkg::OFS_IMM;
	wire logic hit = hit_ctrl | hit_stat | hit_fld | hit_disp | hit_imm;
	wire logic [31:0] stat_w = {19'h0, dec_op32, dec_adr32, dec_seg_bad, dec_imm_len, dec_disp_len, dec_len};
	wire logic [31:0] fld_w = {dec_opcode, dec_mod, dec_mid, dec_rm, dec_ss, dec_index, dec_base,
		dec_pfx_cnt, 3'h0, dec_two_byte};
	wire logic [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl} : hit_stat ? stat_w : hit_fld ? fld_w :
		hit_disp ? dec_disp : hit_imm ? dec_imm : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
			ctrl <= ifd_pkg::CTRL_RST;
		end else begin
			pready <= 1'b1;
			if (psel && !penable) begin
				prdata <= rd_mux;
				pslverr <= !hit;
			end
			if (psel && penable && pready && pwrite && hit_ctrl)
				ctrl <= pwdata[1:0];
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence modrm_sib_s;
		take && state == ifd_pkg::st_modrm && m_sib;
	endsequence
	sequence disp_end_s;
		take && state == ifd_pkg::st_disp && cnt == ifd_pkg::LEN_1 && imm_len != ifd_pkg::LEN_0;
	endsequence

	// RL19 index byte follows
	sib_follow_a: assert property (modrm_sib_s |=> state == ifd_pkg::st_sib) // RL19
		else $error("index byte not expected");
	// RL3 immediate after displacement
	imm_after_a: assert property (disp_end_s |=> state == ifd_pkg::st_imm && cnt == imm_len) // RL3
		else $error("immediate not after displacement");
	// RL16 prefixes dropped
	pfx_clear_a: assert property (fin |=> dec_valid && state == ifd_pkg::st_op && !op_ovr && !adr_ovr) // RL16
		else $error("prefix state leaked");
	// RL14 real mode sizes
	real_size_a: assert property (dec_valid && !$past(prot_mode) |-> dec_op32 == $past(op_ovr)) // RL14
		else $error("real mode operand size wrong");
	// RL18 lane enables
	lane_mask_a: assert property (dec_valid && !dec_w |-> dest_be == ifd_pkg::BE_LO || dest_be == ifd_pkg::BE_HI) // RL18
		else $error("narrow write touches upper lanes");
	// RL21 illegal segment flag
	seg_bad_a: assert property (dec_valid |-> dec_seg_bad == (seg_sel_wide[2:1] == ifd_pkg::SEG_BAD_HI)) // RL21
		else $error("segment flag mismatch");
	// RL22 length sum
	len_sum_a: assert property (dec_valid |-> dec_len == 4'(dec_pfx_cnt + 4'h1 + 4'(dec_two_byte)
		+ 4'(dec_has_modrm) + 4'(dec_has_sib) + 4'(dec_disp_len) + 4'(dec_imm_len))) // RL22
		else $error("length is not field sum");
	// RL9 byte immediate extension
	imm_sext_a: assert property (dec_valid && dec_s && dec_imm_len == ifd_pkg::LEN_1 |->
		dec_imm[15:8] == {8{dec_imm[7]}}) // RL9
		else $error("immediate not sign extended");
	// RL22 fetch pause of one cycle
	ready_gap_a: assert property (fin_now |=> !byte_ready ##1 byte_ready) // RL22
		else $error("ready gap wrong");
endmodule
`default_nettype wire

// file: ifd_fetch_model.sv
// Fetch-side model that streams instruction bytes into the decoder
`timescale 1ns/1ps
`default_nettype none
module ifd_fetch_model (
	input  wire logic       pclk,
	input  wire logic       byte_ready,
	output logic            byte_valid,
	output logic      [7:0] byte_data,
	output logic            attr_modrm,
	output logic      [1:0] attr_imm
);
	initial begin
		byte_valid = 1'b0;
		byte_data  = 8'h00;
		attr_modrm = 1'b0;
		attr_imm   = 2'h0;
	end
	task automatic send(input logic [7:0] q[$], input logic modrm, input logic [1:0] imm, input bit slow,
		output bit ok);
		int n;
		ok = 1'b1;
		@(posedge pclk);
		foreach (q[i]) begin
			if (slow) begin
				byte_valid <= 1'b0;
				byte_data  <= ~byte_data;
				@(posedge pclk);
			end
			byte_valid <= 1'b1;
			byte_data  <= q[i];
			attr_modrm <= modrm;
			attr_imm   <= imm;
			n = 0;
			do begin
				@(posedge pclk);
				n++;
			end while (byte_ready !== 1'b1 && n < 20);
			if (n >= 20)
				ok = 1'b0;
		end
		byte_valid <= 1'b0;
		byte_data  <= ~q[q.size()-1];
	endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench for the instruction field decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, byte_data, dec_opcode;
	logic [31:0] pwdata, prdata, dec_disp, dec_imm, d;
	logic        byte_valid, byte_ready, attr_modrm, dec_valid, dec_two_byte, dec_has_modrm, dec_has_sib;
	logic        dec_w, dec_d, dec_s, dec_reg_hi, dec_seg_bad, dec_cond_neg, dec_op32, dec_adr32, e;
	logic [1:0]  attr_imm, dec_mod, dec_ss, seg_sel_narrow;
	logic [2:0]  dec_mid, dec_rm, dec_index, dec_base, dec_reg_num, seg_sel_wide, dec_disp_len, dec_imm_len;
	logic [3:0]  dec_len, dec_pfx_cnt, dest_be, dec_cond;
	int          n_errors, checked;

	ifd_decoder i_ifd_decoder (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .byte_valid, .byte_data, .byte_ready, .attr_modrm, .attr_imm, .dec_valid,
		.dec_len, .dec_pfx_cnt, .dec_two_byte, .dec_has_modrm, .dec_has_sib, .dec_opcode, .dec_w, .dec_d,
		.dec_s, .dec_mod, .dec_mid, .dec_rm, .dec_ss, .dec_index, .dec_base, .dec_reg_num, .dec_reg_hi,
		.dest_be, .seg_sel_narrow, .seg_sel_wide, .dec_seg_bad, .dec_cond, .dec_cond_neg, .dec_op32,
		.dec_adr32, .dec_disp_len, .dec_imm_len, .dec_disp, .dec_imm);
	ifd_fetch_model i_ifd_fetch_model (.pclk, .byte_ready, .byte_valid, .byte_data, .attr_modrm, .attr_imm);

	always #12.5 pclk = ~pclk;

	// ----------------------------------------
	// Compare and report
	// ----------------------------------------
	task automatic cmp_field(input string what, input logic [31:0] act, input logic [31:0] exp);
		checked++;
		if (act !== exp) begin
			n_errors++;
			$display("ERROR %0t decode %s got %h want %h", $time, what, act, exp);
		end
	endtask
	task automatic cmp_reg(input string what, input logic [31:0] act, input logic [31:0] exp);
		checked++;
		if (act !== exp) begin
			n_errors++;
			$display("ERROR %0t register %s got %h want %h", $time, what, act, exp);
		end
	endtask
	task automatic end_of_test();
		$display("errors %0d comparisons %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------
	// Bus and stream tasks
	// ----------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		d = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			n_errors++;
			$display("ERROR %0t bus answer timed out", $time);
			end_of_test();
		end
	endtask
	task automatic run(input logic [7:0] q[$], input logic modrm, input logic [1:0] imm, input bit slow);
		bit ok;
		int n;
		i_ifd_fetch_model.send(q, modrm, imm, slow, ok);
		n = 0;
		while (dec_valid !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (!ok || n >= 20) begin
			n_errors++;
			$display("ERROR %0t byte stream or decode timed out", $time);
			end_of_test();
		end
	endtask
	task automatic chk(input logic [3:0] len, input logic op32, adr32, sib, input logic [31:0] disp, imm);
		cmp_field("len", dec_len, len);
		cmp_field("op32", dec_op32, op32);
		cmp_field("adr32", dec_adr32, adr32);
		cmp_field("sib", dec_has_sib, sib);
		cmp_field("disp", dec_disp, disp);
		cmp_field("imm", dec_imm, imm);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_errors = 0;
		checked = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ifd_pkg::OFS_CTRL, 32'h0);
		cmp_reg("ctrl", d, 32'h0);
		run('{8'h66, 8'h83, 8'hc0, 8'h05}, 1'b1, 2'h1, 1'b0);
		chk(4'h4, 1'b1, 1'b0, 1'b0, 32'h0, 32'h5);
		cmp_field("be", dest_be, 4'hf);
		run('{8'h83, 8'hc1, 8'h80}, 1'b1, 2'h1, 1'b1);
		chk(4'h3, 1'b0, 1'b0, 1'b0, 32'h0, 32'h0000ff80);
		cmp_field("modrm", {dec_mod, dec_mid, dec_rm}, 8'hc1);
		cmp_field("wds", {dec_w, dec_d, dec_s}, 3'h7);
		cmp_field("be", dest_be, 4'h3);
		apb(1'b1, ifd_pkg::OFS_CTRL, 32'h3);
		run('{8'h8b, 8'h44, 8'h8d, 8'hf0}, 1'b1, 2'h0, 1'b0);
		chk(4'h4, 1'b1, 1'b1, 1'b1, 32'hf0, 32'h0);
		cmp_field("sibf", {dec_ss, dec_index, dec_base}, 8'h8d);
		apb(1'b0, ifd_pkg::OFS_STAT, 32'h0);
		cmp_reg("stat", d, 32'h1814);
		apb(1'b1, ifd_pkg::OFS_DISP, 32'h0);
		apb(1'b0, ifd_pkg::OFS_DISP, 32'h0);
		cmp_reg("disp", d, 32'hf0);
		apb(1'b0, 8'h14, 32'h0);
		cmp_reg("err", {e, d[30:0]}, 32'h80000000);
		run('{8'h8b, 8'h05, 8'h78, 8'h56, 8'h34, 8'h12}, 1'b1, 2'h0, 1'b1);
		chk(4'h6, 1'b1, 1'b1, 1'b0, 32'h12345678, 32'h0);
		for (int k = 0; k < 2; k++) begin
			run('{k ? 8'h66 : 8'h67, k ? 8'h67 : 8'h66, 8'h81, 8'h06, 8'h34, 8'h12, 8'h78, 8'h56},
				1'b1, 2'h3, 1'b0);
			chk(4'h8, 1'b0, 1'b0, 1'b0, 32'h1234, 32'h5678);
			cmp_field("pfx", dec_pfx_cnt, 4'h2);
		end
		run('{8'h83, 8'hc1, 8'h80}, 1'b1, 2'h1, 1'b0);
		chk(4'h3, 1'b1, 1'b1, 1'b0, 32'h0, 32'hffffff80);
		run('{8'h0f, 8'h85, 8'h78, 8'h56, 8'h34, 8'h12}, 1'b0, 2'h3, 1'b0);
		chk(4'h6, 1'b1, 1'b1, 1'b0, 32'h0, 32'h12345678);
		cmp_field("cond", {dec_two_byte, dec_has_modrm, dec_cond, dec_cond_neg}, 7'h4b);
		cmp_field("op", {dec_opcode, dec_reg_num}, 11'h42d);
		apb(1'b0, ifd_pkg::OFS_IMM, 32'h0);
		cmp_reg("imm", d, 32'h12345678);
		apb(1'b1, ifd_pkg::OFS_CTRL, 32'h1);
		run('{8'h66, 8'h67, 8'h8a, 8'h24, 8'h98}, 1'b1, 2'h0, 1'b1);
		chk(4'h5, 1'b1, 1'b1, 1'b1, 32'h0, 32'h0);
		cmp_field("reg", {dec_reg_hi, dec_reg_num}, 4'h8);
		cmp_field("be", dest_be, 4'h2);
		cmp_field("seg", {dec_seg_bad, seg_sel_wide}, 4'h4);
		run('{8'h8b, 8'h84, 8'h34, 8'h12}, 1'b1, 2'h0, 1'b0);
		chk(4'h4, 1'b0, 1'b0, 1'b0, 32'h1234, 32'h0);
		run('{8'h8e, 8'hf8}, 1'b1, 2'h0, 1'b0);
		cmp_field("seg", {dec_seg_bad, seg_sel_wide, seg_sel_narrow}, 6'h3d);
		apb(1'b0, ifd_pkg::OFS_FLD, 32'h0);
		cmp_reg("fld", d, 32'h8ef89800);
		end_of_test();
	end
endmodule
`default_nettype wire
